/* File: logic/irlp_pkg.sv */
//------------------------------------------------------------------------------
// Package for the interrupt priority resolver: register offsets, field
// positions, reset values, event codes and the carrier type.
// Assumes a 250 MHz peripheral clock and a 32-bit AXI4-Lite register bus.
//------------------------------------------------------------------------------
`default_nettype none

package irlp_pkg;

    //--------------------------------------------------------------------------
    // Register byte offsets
    //--------------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_PRIA  = 8'h04;
    localparam logic [7:0] OFF_PRIB  = 8'h08;
    localparam logic [7:0] OFF_PRID  = 8'h0C;
    localparam logic [7:0] OFF_PRIE  = 8'h10;
    localparam logic [7:0] OFF_EVT   = 8'h14;
    localparam logic [7:0] OFF_EVT2  = 8'h18;
    localparam logic [7:0] OFF_ISTAT = 8'h1C;
    localparam logic [7:0] OFF_IMASK = 8'h20;
    localparam logic [7:0] OFF_STATE = 8'h24;

    // Control register 1 field positions
    localparam int CTRL1_LVL_SEL_BIT = 0;
    localparam int CTRL1_SEC_EN_BIT  = 1;

    // Reset values
    localparam logic [15:0] RST_REG16  = 16'h0000;
    localparam logic [11:0] RST_CODE   = 12'h000;
    localparam logic [3:0]  RST_PINS_N = 4'hF;
    localparam logic [1:0]  RST_IRQ2   = 2'h0;

    // Interrupt status bits
    localparam int IST_ACCEPT_BIT = 0;
    localparam int IST_WAKE_BIT   = 1;

    // Source indices, in fixed default order (lowest index wins a tie)
    localparam int NSRC    = 15;
    localparam int SRC_DBG = 0;
    localparam int SRC_ENC = 1;
    localparam int SRC_PL  = 2;
    localparam int SRC_PH  = 3;
    localparam int SRC_TM0 = 4;
    localparam int SRC_TM1 = 5;
    localparam int SRC_TM2 = 6;
    localparam int SRC_RTC = 7;
    localparam int SRC_SCI = 8;
    localparam int SRC_WDT = 9;
    localparam int SRC_BSC = 10;
    localparam int SRC_DMA = 11;
    localparam int SRC_IRD = 12;
    localparam int SRC_SCF = 13;
    localparam int SRC_ADC = 14;
    localparam int NPERIPH = 11;

    // Fixed levels and event codes
    localparam logic [3:0]  LVL_DEBUG     = 4'hF;
    localparam logic [3:0]  LVL_NONE      = 4'h0;
    localparam logic [11:0] CODE_ENC_BASE = 12'h200;
    localparam logic [11:0] CODE_DBG      = 12'h5E0;
    localparam logic [11:0] CODE_PL       = 12'h700;
    localparam logic [11:0] CODE_PH       = 12'h720;
    localparam logic [11:0] CODE_TM0      = 12'h400;
    localparam logic [11:0] CODE_TM1      = 12'h420;
    localparam logic [11:0] CODE_TM2      = 12'h440;
    localparam logic [11:0] CODE_RTC      = 12'h480;
    localparam logic [11:0] CODE_SCI      = 12'h4E0;
    localparam logic [11:0] CODE_WDT      = 12'h560;
    localparam logic [11:0] CODE_BSC      = 12'h580;
    localparam logic [11:0] CODE_DMA      = 12'h800;
    localparam logic [11:0] CODE_IRD      = 12'h880;
    localparam logic [11:0] CODE_SCF      = 12'h900;
    localparam logic [11:0] CODE_ADC      = 12'h980;
    localparam logic [31:0] HANDLER_ADDR  = 32'h0000_0600;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    //--------------------------------------------------------------------------
    // Carrier: request presented to the processor core
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [3:0]  level;
        logic [11:0] code;
    } irlp_core_req_t;

endpackage

`default_nettype wire

/* File: logic/irlp_level_filter.sv */
//------------------------------------------------------------------------------
// Noise filter for one active-low 4-bit encoded priority pin group.
// Assumes raw pins from outside the clock domain; i_sample is a same-clock
// strobe (every cycle normally, 32-kHz ticks in standby).
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module irlp_level_filter
    import irlp_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_pins_n,
    input  wire logic       i_sample,
    output logic      [3:0] o_level
);

    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] last_q;

    // Two-flop synchroniser; only the second stage is used below
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_q <= RST_PINS_N;
            sync2_q <= RST_PINS_N;
        end
        else
        begin
            sync1_q <= i_pins_n;
            sync2_q <= sync1_q;
        end
    end

    // Accept a value only after two identical consecutive samples
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            last_q  <= RST_PINS_N;
            o_level <= LVL_NONE;
        end
        else if (i_sample)
        begin
            last_q <= sync2_q;
            if (sync2_q == last_q)
                o_level <= 4'hF - sync2_q;
        end
    end

    // Level only moves after two matching samples
    AST_FILTER_TWO_SAMPLES: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $changed(o_level) |-> $past(i_sample) && $past(sync2_q) == $past(last_q))
        else $error("encoded level changed without two matching samples");

endmodule // irlp_level_filter

`default_nettype wire

/* File: logic/irlp_resolver.sv */
//------------------------------------------------------------------------------
// Interrupt priority resolver: encoded pin groups, port pins and on-chip
// peripheral requests, with AXI4-Lite registers and a level interrupt.
// Assumes core signals and peripheral requests share i_clk; pins do not.
//------------------------------------------------------------------------------
// Behaviour
// - Secondary pin group counts only when level select and group enable are set.
// - With both groups active, the higher decoded level is taken.
// - Encoded value decodes to fifteen minus value; all ones is no request.
// - Pins sampled each cycle; new level needs two identical consecutive samples.
// - In standby, filtering runs on 32-kHz ticks; none means no wake.
// - Taking any interrupt leaves the core status mask untouched.
// - Sixteen level port pins, two groups of eight, priorities in register D.
// - Port pins 0 and 1 wake from standby above mask, oscillator running.
// - Peripherals prioritised via registers A, B, E; debug fixed at 15.
// - Accepted source code goes into both event registers; one handler.
// - Reset clears every programmable priority field to zero.
// - Equal priorities arriving together are served in fixed default order.
// - Timer and clock requests wake from standby above mask, oscillator running.
// - A source at priority zero never reaches the core; timer and clock wake compares best_lvl to the mask.
`timescale 1ns/1ps
`default_nettype none

module irlp_resolver
    import irlp_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]           i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [7:0]           i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    // Request sources
    input  wire logic [3:0]           i_encoded_level_pins_primary_n,
    input  wire logic [3:0]           i_encoded_level_pins_secondary_n,
    input  wire logic [15:0]          i_port_int_pins,
    input  wire logic [NPERIPH-1:0]   i_periph_req,
    input  wire logic                 i_debug_interface_req,
    // Standby and real-time clock
    input  wire logic                 i_standby,
    input  wire logic                 i_rtc_clk,
    input  wire logic                 i_rtc_osc_run,
    // Processor core
    input  wire logic [3:0]           i_status_mask_level,
    input  wire logic                 i_core_ack,
    output irlp_core_req_t            o_core_req,
    output logic [31:0]               o_handler_addr,
    output logic                      o_wake,
    output logic                      o_irq
);

    //--------------------------------------------------------------------------
    // Registers and synchronisers
    //--------------------------------------------------------------------------
    logic [15:0] ctrl1_q, pria_q, prib_q, prid_q, prie_q;
    logic [11:0] evt_q, evt2_q;
    logic [1:0]  istat_q, imask_q;
    logic [15:0] port_s1_q, port_s2_q;
    logic [2:0]  rtc_sync_q;
    logic [3:0]  prim_lvl, sec_lvl, enc_lvl;
    logic        sec_used, sample, rtc_tick;

    // Pins and the 32-kHz clock pass two flops before use
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            port_s1_q  <= RST_REG16;
            port_s2_q  <= RST_REG16;
            rtc_sync_q <= 3'h0;
        end
        else
        begin
            port_s1_q  <= i_port_int_pins;
            port_s2_q  <= port_s1_q;
            rtc_sync_q <= {rtc_sync_q[1:0], i_rtc_clk};
        end
    end

    // Standby has no usable peripheral clock edge, so filters step on RTC ticks
    assign rtc_tick = rtc_sync_q[1] & ~rtc_sync_q[2];
    assign sample   = i_standby ? (rtc_tick & i_rtc_osc_run) : 1'b1;

    //--------------------------------------------------------------------------
    // Encoded pin groups
    //--------------------------------------------------------------------------
    irlp_level_filter u_filt_prim (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_pins_n (i_encoded_level_pins_primary_n),
        .i_sample (sample),
        .o_level  (prim_lvl)
    );

    irlp_level_filter u_filt_sec (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_pins_n (i_encoded_level_pins_secondary_n),
        .i_sample (sample),
        .o_level  (sec_lvl)
    );

    assign sec_used = ctrl1_q[CTRL1_LVL_SEL_BIT] & ctrl1_q[CTRL1_SEC_EN_BIT];
    assign enc_lvl  = (sec_used && sec_lvl > prim_lvl) ? sec_lvl : prim_lvl;

    //--------------------------------------------------------------------------
    // Source table and resolution
    //--------------------------------------------------------------------------
    logic [3:0]  src_lvl [NSRC];
    logic [11:0] src_code[NSRC];
    logic [NSRC-1:0] src_req;
    logic [3:0]  best_lvl;
    logic [11:0] best_code;

    assign src_req = {i_periph_req, |port_s2_q[15:8], |port_s2_q[7:0],
                      enc_lvl != LVL_NONE, i_debug_interface_req};
    assign src_lvl[SRC_DBG] = LVL_DEBUG;
    assign src_lvl[SRC_ENC] = enc_lvl;
    assign src_lvl[SRC_PL]  = prid_q[15:12];
    assign src_lvl[SRC_PH]  = prid_q[11:8];
    assign src_lvl[SRC_TM0] = pria_q[15:12];
    assign src_lvl[SRC_TM1] = pria_q[11:8];
    assign src_lvl[SRC_TM2] = pria_q[7:4];
    assign src_lvl[SRC_RTC] = pria_q[3:0];
    assign src_lvl[SRC_SCI] = prib_q[7:4];
    assign src_lvl[SRC_WDT] = prib_q[15:12];
    assign src_lvl[SRC_BSC] = prib_q[11:8];
    assign src_lvl[SRC_DMA] = prie_q[15:12];
    assign src_lvl[SRC_IRD] = prie_q[11:8];
    assign src_lvl[SRC_SCF] = prie_q[7:4];
    assign src_lvl[SRC_ADC] = prie_q[3:0];
    assign src_code[SRC_DBG] = CODE_DBG;
    assign src_code[SRC_ENC] = CODE_ENC_BASE + {3'b000, ~enc_lvl, 5'b0_0000};
    assign src_code[SRC_PL]  = CODE_PL;
    assign src_code[SRC_PH]  = CODE_PH;
    assign src_code[SRC_TM0] = CODE_TM0;
    assign src_code[SRC_TM1] = CODE_TM1;
    assign src_code[SRC_TM2] = CODE_TM2;
    assign src_code[SRC_RTC] = CODE_RTC;
    assign src_code[SRC_SCI] = CODE_SCI;
    assign src_code[SRC_WDT] = CODE_WDT;
    assign src_code[SRC_BSC] = CODE_BSC;
    assign src_code[SRC_DMA] = CODE_DMA;
    assign src_code[SRC_IRD] = CODE_IRD;
    assign src_code[SRC_SCF] = CODE_SCF;
    assign src_code[SRC_ADC] = CODE_ADC;

    // Strict compare keeps the earlier source on a tie
    always_comb
    begin
        best_lvl  = LVL_NONE;
        best_code = RST_CODE;
        for (int i = 0; i < NSRC; i++)
        begin
            if (src_req[i] && src_lvl[i] > best_lvl)
            begin
                best_lvl  = src_lvl[i];
                best_code = src_code[i];
            end
        end
    end

    //--------------------------------------------------------------------------
    // Core request, event codes and wake
    //--------------------------------------------------------------------------
    logic wake_d, accept;

    // Core sees a request only above its own mask level
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_core_req <= '0;
        else
        begin
            o_core_req.valid <= best_lvl > i_status_mask_level;
            o_core_req.level <= best_lvl;
            o_core_req.code  <= best_code;
        end
    end

    // Status mask is the core's; this block only reads it, never writes it
    assign accept = i_core_ack & o_core_req.valid;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            evt_q  <= RST_CODE;
            evt2_q <= RST_CODE;
        end
        else if (accept)
        begin
            evt_q  <= o_core_req.code;
            evt2_q <= o_core_req.code;
        end
    end

    // Every source enters through the same handler
    assign o_handler_addr = HANDLER_ADDR;

    // Wake needs the 32-kHz oscillator; encoded level is already RTC-filtered
    assign wake_d = i_standby & i_rtc_osc_run & (
        (enc_lvl > i_status_mask_level) |
        (|port_s2_q[1:0] & (prid_q[15:12] > i_status_mask_level)) |
        (|i_periph_req[SRC_RTC-SRC_TM0:0] &&
         best_lvl > i_status_mask_level));

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_wake <= 1'b0;
        else
            o_wake <= wake_d;
    end

    //--------------------------------------------------------------------------
    // AXI4-Lite slave
    //--------------------------------------------------------------------------
    logic        aw_have_q, w_have_q, wr_go, rd_hit;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rd_d;
    logic [3:0]  wstrb_q;
    logic [15:0] wmask;
    logic [1:0]  ist_set;

    assign o_awready = ~aw_have_q & ~o_bvalid;
    assign o_wready  = ~w_have_q & ~o_bvalid;
    assign o_arready = ~o_rvalid;
    assign wr_go     = aw_have_q & w_have_q & ~o_bvalid;
    assign wmask     = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Address and data are taken independently and held until the write
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
            end
            if (wr_go)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= (awaddr_q <= OFF_STATE && awaddr_q[1:0] == 2'b00)
                             ? RESP_OKAY : RESP_SLVERR;
            end
            else if (i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // Writable registers; reset clears all priority fields
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl1_q <= RST_REG16;
            pria_q  <= RST_REG16;
            prib_q  <= RST_REG16;
            prid_q  <= RST_REG16;
            prie_q  <= RST_REG16;
            imask_q <= RST_IRQ2;
        end
        else if (wr_go)
        begin
            case (awaddr_q)
                OFF_CTRL1: ctrl1_q <= (ctrl1_q & ~wmask) | (wdata_q[15:0] & wmask);
                OFF_PRIA:  pria_q  <= (pria_q & ~wmask) | (wdata_q[15:0] & wmask);
                OFF_PRIB:  prib_q  <= (prib_q & ~wmask) | (wdata_q[15:0] & wmask);
                OFF_PRID:  prid_q  <= (prid_q & ~wmask) | (wdata_q[15:0] & wmask);
                OFF_PRIE:  prie_q  <= (prie_q & ~wmask) | (wdata_q[15:0] & wmask);
                OFF_IMASK: if (wstrb_q[0]) imask_q <= wdata_q[1:0];
                default:   ;
            endcase
        end
    end

    // Sticky status: a new event wins over a write-one clear in the same cycle
    assign ist_set = {wake_d & ~o_wake, accept};
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            istat_q <= RST_IRQ2;
        else if (wr_go && awaddr_q == OFF_ISTAT && wstrb_q[0])
            istat_q <= (istat_q & ~wdata_q[1:0]) | ist_set;
        else
            istat_q <= istat_q | ist_set;
    end

    assign o_irq = |(istat_q & imask_q);

    // Read mux; unmapped offsets answer SLVERR with zero data
    always_comb
    begin
        rd_hit = 1'b1;
        case (i_araddr)
            OFF_CTRL1: rd_d = {16'h0000, ctrl1_q};
            OFF_PRIA:  rd_d = {16'h0000, pria_q};
            OFF_PRIB:  rd_d = {16'h0000, prib_q};
            OFF_PRID:  rd_d = {16'h0000, prid_q};
            OFF_PRIE:  rd_d = {16'h0000, prie_q};
            OFF_EVT:   rd_d = {20'h0_0000, evt_q};
            OFF_EVT2:  rd_d = {20'h0_0000, evt2_q};
            OFF_ISTAT: rd_d = {30'h0000_0000, istat_q};
            OFF_IMASK: rd_d = {30'h0000_0000, imask_q};
            OFF_STATE: rd_d = {16'h0000, best_lvl, sec_lvl, prim_lvl, enc_lvl};
            default:
            begin
                rd_d   = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_d;
            o_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (i_rready)
            o_rvalid <= 1'b0;
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_SEC_IGNORED: assert property (!sec_used |-> enc_lvl == prim_lvl)
        else $error("secondary group used while disabled");
    AST_SEC_HIGHER: assert property (sec_used |-> enc_lvl >= prim_lvl && enc_lvl >= sec_lvl)
        else $error("encoded level is not the higher group");
    AST_ENC_DECODE: assert property (
        (!i_standby && $stable(i_encoded_level_pins_primary_n))[*6]
        |-> prim_lvl == 4'hF - i_encoded_level_pins_primary_n)
        else $error("stable encoded pins decode wrongly");
    AST_REQ_ABOVE_MASK: assert property (
        o_core_req.valid |-> o_core_req.level > $past(i_status_mask_level))
        else $error("core request not above status mask");
    AST_ZERO_MASKED: assert property (
        o_core_req.valid |-> o_core_req.level != LVL_NONE)
        else $error("priority zero source presented");
    AST_EVT_BOTH: assert property (
        accept |=> evt_q == $past(o_core_req.code) && evt2_q == evt_q)
        else $error("event codes not written on accept");
    AST_DEBUG_FIRST: assert property (
        i_debug_interface_req && i_status_mask_level != LVL_DEBUG
        |=> o_core_req.valid && o_core_req.code == CODE_DBG)
        else $error("debug request not served first at level 15");
    AST_PORT_WAKE: assert property (
        i_standby && i_rtc_osc_run && port_s2_q[0] &&
        prid_q[15:12] > i_status_mask_level |=> o_wake)
        else $error("port pin 0 failed to wake");
    AST_NO_WAKE_NO_RTC: assert property (!i_rtc_osc_run |=> !o_wake)
        else $error("wake without 32-kHz oscillator");

    COV_ACCEPT:   cover property (accept);
    COV_SEC_WINS: cover property (sec_used && sec_lvl > prim_lvl);
    COV_WAKE:     cover property ($rose(o_wake));
    COV_IRQ:      cover property ($rose(o_irq));

endmodule // irlp_resolver

`default_nettype wire

/* File: verification/irlp_core_model.sv */
// Processor core model: accepts the presented request.
// Assumes it shares the resolver's clock.
`timescale 1ns/1ps
`default_nettype none
module irlp_core_model import irlp_pkg::*; (
    input  wire logic           i_clk,
    input  wire logic           i_en,
    input  wire irlp_core_req_t i_req,
    output logic                o_ack
);
    initial o_ack = 1'b0;
    // One-cycle accept pulse; the model never touches the status mask
    always @(posedge i_clk) o_ack <= i_en && i_req.valid && !o_ack;
endmodule // irlp_core_model
`default_nettype wire

/* File: verification/irl_pint_priority_resolver_tb.sv */
// Testbench for the interrupt priority resolver.
// Assumes the register map and event codes of irlp_pkg.
`timescale 1ns/1ps
`default_nettype none
module irl_pint_priority_resolver_tb;
import irlp_pkg::*;
logic i_clk=0, i_rst_n=0, i_awvalid=0, i_wvalid=0, i_bready=0, i_arvalid=0, i_rready=0;
logic [7:0] i_awaddr=0, i_araddr=0;
logic [31:0] i_wdata=0, o_rdata, o_handler_addr;
logic [3:0] i_wstrb=4'hF, i_status_mask_level=0;
logic [3:0] i_encoded_level_pins_primary_n=4'hF, i_encoded_level_pins_secondary_n=4'hF;
logic [15:0] i_port_int_pins=0;
logic [NPERIPH-1:0] i_periph_req=0;
logic i_debug_interface_req=0, i_standby=0, i_rtc_clk=0, i_rtc_osc_run=1, i_core_ack, ack_en=0;
logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wake, o_irq;
logic [1:0] o_bresp, o_rresp;
irlp_core_req_t o_core_req;
int err_total=0, checks_done=0;
always #2 i_clk = ~i_clk;
irlp_resolver DUT (.*);
irlp_core_model CORE (.i_clk(i_clk), .i_en(ack_en), .i_req(o_core_req), .o_ack(i_core_ack));
task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
        err_total++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
// Bus tasks decide at the falling edge, act at the next rising edge
task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic [2:0] k;
    logic [1:0] b;
    @(posedge i_clk);
    i_awaddr <= a; i_wdata <= d; i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1;
    for (n = 0; n < 50; n++)
    begin
        @(negedge i_clk);
        k = {o_awready & i_awvalid, o_wready & i_wvalid, o_bvalid};
        b = o_bresp;
        @(posedge i_clk);
        if (k[2]) i_awvalid <= 0;
        if (k[1]) i_wvalid <= 0;
        if (k[0]) i_bready <= 0;
        if (k[0]) break;
    end
    if (n == 50) begin err_total++; conclude(); end
    // Every write in these tests targets a mapped register
    chk({30'h0, b}, {30'h0, RESP_OKAY});
endtask
task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic [33:0] v;
    @(posedge i_clk);
    i_araddr <= a; i_arvalid <= 1; i_rready <= 1;
    for (n = 0; n < 50; n++)
    begin
        @(negedge i_clk);
        v = {o_rresp, o_rdata};
        if (o_rvalid === 1'b1) break;
        if (o_arready === 1'b1) @(posedge i_clk) i_arvalid <= 0;
    end
    @(posedge i_clk) i_rready <= 0;
    if (n == 50) begin err_total++; conclude(); end
    chk(v[31:0], d);
    chk({30'h0, v[33:32]}, {30'h0, r});
endtask
// Poll the core request under a bound, then compare level and code
task req(input logic [3:0] l, input logic [11:0] c);
    for (int n = 0; n < 40 && o_core_req.level !== l; n++) @(negedge i_clk);
    chk(o_core_req.valid, 1); chk(o_core_req.level, l); chk(o_core_req.code, c);
endtask
task quiet;
    repeat (10) @(negedge i_clk);
    chk(o_core_req.valid, 0);
endtask
initial
begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1;
    rd(OFF_PRIA, 0, RESP_OKAY);
    rd(OFF_PRID, 0, RESP_OKAY);
    rd(8'h40, 0, RESP_SLVERR);
    chk(o_handler_addr, HANDLER_ADDR);
    @(posedge i_clk) i_port_int_pins <= 16'h0101;
    quiet();
    wr(OFF_PRID, 32'h0000_5500);
    req(4'h5, CODE_PL);
    @(posedge i_clk) i_status_mask_level <= 4'h5;
    quiet();
    @(posedge i_clk) i_encoded_level_pins_primary_n <= 4'h2;
    i_encoded_level_pins_secondary_n <= 4'h0;
    req(4'hD, CODE_ENC_BASE + 12'h040);
    wr(OFF_CTRL1, 32'h0000_0003);
    req(4'hF, CODE_ENC_BASE);
    wr(OFF_PRIA, 32'h0000_7000);
    // The encoded source may only drop its level once it has been accepted
    @(posedge i_clk) ack_en <= 1;
    repeat (2) @(posedge i_clk);
    ack_en <= 0;
    rd(OFF_EVT, CODE_ENC_BASE, RESP_OKAY);
    @(posedge i_clk) i_encoded_level_pins_primary_n <= 4'hF;
    i_encoded_level_pins_secondary_n <= 4'hF; i_periph_req <= 1;
    req(4'h7, CODE_TM0);
    @(posedge i_clk) i_debug_interface_req <= 1; ack_en <= 1;
    repeat (6) @(posedge i_clk);
    ack_en <= 0;
    rd(OFF_EVT, CODE_DBG, RESP_OKAY);
    rd(OFF_EVT2, CODE_DBG, RESP_OKAY);
    rd(OFF_ISTAT, 1, RESP_OKAY);
    wr(OFF_IMASK, 1);
    @(negedge i_clk) chk(o_irq, 1);
    wr(OFF_IMASK, 0);
    @(negedge i_clk) chk(o_irq, 0);
    wr(OFF_IMASK, 1);
    wr(OFF_ISTAT, 1);
    @(negedge i_clk) chk(o_irq, 0);
    rd(OFF_ISTAT, 0, RESP_OKAY);
    // Standby: port pin 0 wakes alone, then a timer once the ports are masked
    @(posedge i_clk) i_periph_req <= 0; i_status_mask_level <= 4'h4; i_standby <= 1;
    repeat (3) @(negedge i_clk);
    chk(o_wake, 1);
    rd(OFF_ISTAT, 2, RESP_OKAY);
    @(posedge i_clk) i_rtc_osc_run <= 0;
    repeat (3) @(negedge i_clk);
    chk(o_wake, 0);
    wr(OFF_PRID, 0);
    @(posedge i_clk) i_rtc_osc_run <= 1; i_periph_req <= 1;
    repeat (3) @(negedge i_clk);
    chk(o_wake, 1);
    conclude();
end
endmodule // irl_pint_priority_resolver_tb
`default_nettype wire
